/* File: logic/uarx_top.sv */
`include "uarx_cfg.svh"
`default_nettype none
module uarx_top
(
  input  wire logic       CLK_IN,
  input  wire logic       RESETN_IN,
  input  wire logic [7:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output uarx_pkg::uarx_byte_type RDATA_OUT,
  input  wire logic       GLOBAL_IRQ_EN_IN,
  input  wire logic       TX_LOADED_IN,
  input  wire logic       TX_IDLE_DONE_IN,
  input  wire logic       TXC_VECTOR_ACK_IN,
  output logic [7:0]      TX_DATA_OUT,
  output logic            TX_NINTH_OUT,
  input  wire logic       SHARED_INPUT_PIN_IN,
  input  wire logic       PIN_GPIO_OUT_IN,
  output logic            PIN_OUT,
  output logic            PIN_OE_OUT,
  output logic            PIN_PULLUP_OUT,
  output logic            RX_IRQ_OUT,
  output logic            TXC_IRQ_OUT,
  output logic            EMPTY_IRQ_OUT
);
  import uarx_pkg::*;
  uarx_char_if chr ();
  logic [7:0] uart_control_reg;
  logic [7:0] baud_divisor_reg;
  logic [1:0] port_direction_reg;
  logic [7:0] rx_buffer_reg;
  logic       rx_done_flag;
  logic       tx_done_flag;
  logic       tx_buffer_empty_flag;
  logic       framing_error_flag;
  logic       overrun_flag;
  logic       overrun_pending_reg;
  logic       rx_ninth_bit;
  logic       receiver_enable_bit;
  logic       data_wr;
  logic       data_rd;
  logic       ctl_wr;
  logic       accept;
  logic       drop;
  uarx_byte_type status_value;
  assign receiver_enable_bit = uart_control_reg[`UARX_CTL_RECEIVER_ENABLE_BIT];
  assign data_wr = WR_IN && ADDR_IN == `UARX_ADDR_DATA;
  assign data_rd = RD_IN && ADDR_IN == `UARX_ADDR_DATA;
  assign ctl_wr  = WR_IN && ADDR_IN == `UARX_ADDR_CONTROL;
  assign accept  = chr.done && (!rx_done_flag || data_rd);
  assign drop    = chr.done && !accept;
  uarx_tick u_tick
  (
    .clk_in     (CLK_IN),
    .resetn_in  (RESETN_IN),
    .divisor_in (baud_divisor_reg),
    .tick_out   (chr.tick)
  );
  uarx_rx_core u_core
  (
    .clk_in    (CLK_IN),
    .resetn_in (RESETN_IN),
    .enable_in (receiver_enable_bit),
    .nine_in   (uart_control_reg[`UARX_CTL_NINE]),
    .line_in   (SHARED_INPUT_PIN_IN),
    .chr       (chr)
  );
  // =============================================================
  // software configuration registers
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      uart_control_reg   <= `UARX_CONTROL_RESET;
      baud_divisor_reg   <= `UARX_DIVISOR_RESET;
      port_direction_reg <= 2'h0;
    end
    else
    begin
      if (ctl_wr)
        uart_control_reg <= WDATA_IN;
      if (WR_IN && ADDR_IN == `UARX_ADDR_DIVISOR)
        baud_divisor_reg <= WDATA_IN;
      if (WR_IN && ADDR_IN == `UARX_ADDR_PORT)
        port_direction_reg <= WDATA_IN[1:0];
    end
  end
  // =============================================================
  // receive buffer and ninth bit, separate from transmit buffer
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      rx_buffer_reg <= 8'h00;
      rx_ninth_bit  <= 1'b0;
      TX_DATA_OUT   <= 8'h00;
    end
    else
    begin
      if (accept)
      begin
        rx_buffer_reg <= chr.data[7:0];
        if (uart_control_reg[`UARX_CTL_NINE])
          rx_ninth_bit <= chr.data[8];
      end
      if (data_wr)
        TX_DATA_OUT <= WDATA_IN;
    end
  end
  assign TX_NINTH_OUT = uart_control_reg[`UARX_CTL_TX_NINTH_BIT];
  // =============================================================
  // receive status flags
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      rx_done_flag        <= 1'b0;
      framing_error_flag  <= 1'b0;
      overrun_flag        <= 1'b0;
      overrun_pending_reg <= 1'b0;
    end
    else
    begin
      if (accept)
        rx_done_flag <= 1'b1;
      else if (data_rd)
        rx_done_flag <= 1'b0;
      if (accept && !chr.stop_ok)
        framing_error_flag <= 1'b1;
      else if (accept)
        framing_error_flag <= 1'b0;
      // overrun held back until the pending character is read
      if (drop)
        overrun_pending_reg <= 1'b1;
      else if (data_rd)
        overrun_pending_reg <= 1'b0;
      // set wins: a lost character stays reported past a same-cycle accept
      if (data_rd && overrun_pending_reg && receiver_enable_bit)
        overrun_flag <= 1'b1;
      else if (accept)
        overrun_flag <= 1'b0;
    end
  end
  // =============================================================
  // transmit status flags
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      tx_done_flag         <= 1'b0;
      tx_buffer_empty_flag <= 1'b1;
    end
    else
    begin
      if (TX_IDLE_DONE_IN && receiver_enable_bit)
        tx_done_flag <= 1'b1;
      else if (TXC_VECTOR_ACK_IN || (WR_IN && ADDR_IN ==
               `UARX_ADDR_STATUS && WDATA_IN[`UARX_ST_TXC]))
        tx_done_flag <= 1'b0;
      if (TX_LOADED_IN)
        tx_buffer_empty_flag <= 1'b1;
      else if (data_wr)
        tx_buffer_empty_flag <= 1'b0;
    end
  end
  // =============================================================
  // register read port
  always_comb
  begin
    status_value = 8'h00;
    status_value[`UARX_ST_RXC]   = rx_done_flag;
    status_value[`UARX_ST_TXC]   = tx_done_flag;
    status_value[`UARX_ST_EMPTY] = tx_buffer_empty_flag;
    status_value[`UARX_ST_FE]    = framing_error_flag;
    status_value[`UARX_ST_OR]    = overrun_flag;
  end
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
      RDATA_OUT <= 8'h00;
    else if (RD_IN)
    begin
      case (ADDR_IN)
        `UARX_ADDR_DATA:    RDATA_OUT <= rx_buffer_reg;
        `UARX_ADDR_STATUS:  RDATA_OUT <= status_value;
        `UARX_ADDR_CONTROL:
          RDATA_OUT <= {uart_control_reg[7:2], rx_ninth_bit, 1'b0};
        `UARX_ADDR_DIVISOR: RDATA_OUT <= baud_divisor_reg;
        `UARX_ADDR_PORT:    RDATA_OUT <= {6'h00, port_direction_reg};
        default:            RDATA_OUT <= 8'h00;
      endcase
    end
  end
  // =============================================================
  // shared pin and interrupt requests
  assign PIN_OUT    = PIN_GPIO_OUT_IN;
  assign PIN_OE_OUT = !receiver_enable_bit
                      && port_direction_reg[`UARX_PORT_DIR];
  assign PIN_PULLUP_OUT = port_direction_reg[`UARX_PORT_PULL];
  assign RX_IRQ_OUT = GLOBAL_IRQ_EN_IN && rx_done_flag
                      && uart_control_reg[`UARX_CTL_RXIE];
  assign TXC_IRQ_OUT = GLOBAL_IRQ_EN_IN && tx_done_flag
                       && uart_control_reg[`UARX_CTL_TXIE];
  assign EMPTY_IRQ_OUT = GLOBAL_IRQ_EN_IN && tx_buffer_empty_flag
                         && uart_control_reg[`UARX_CTL_EMIE];
endmodule
`default_nettype wire

/* File: logic/uarx_cfg.svh */
`ifndef UARX_CFG_SVH
`define UARX_CFG_SVH
// =============================================================
// register offsets
`define UARX_ADDR_DATA     8'h0C
`define UARX_ADDR_STATUS   8'h0B
`define UARX_ADDR_CONTROL  8'h0A
`define UARX_ADDR_DIVISOR  8'h09
`define UARX_ADDR_PORT     8'h08
// =============================================================
// field positions
`define UARX_CTL_RXIE   7
`define UARX_CTL_TXIE   6
`define UARX_CTL_EMIE   5
`define UARX_CTL_RECEIVER_ENABLE_BIT   4
`define UARX_CTL_TXEN   3
`define UARX_CTL_NINE   2
`define UARX_CTL_RX_NINTH_BIT   1
`define UARX_CTL_TX_NINTH_BIT   0
`define UARX_ST_RXC     7
`define UARX_ST_TXC     6
`define UARX_ST_EMPTY   5
`define UARX_ST_FE      4
`define UARX_ST_OR      3
`define UARX_PORT_DIR   0
`define UARX_PORT_PULL  1
// =============================================================
// reset values and timing
`define UARX_CONTROL_RESET  8'h00
`define UARX_DIVISOR_RESET  8'h00
`define UARX_OVERSAMPLE     4'hF
`define UARX_SAMPLE_A       4'h7
`define UARX_SAMPLE_B       4'h8
`define UARX_SAMPLE_C       4'h9
`define UARX_BITS_EIGHT     4'h8
`define UARX_BITS_NINE      4'h9
`endif

/* File: logic/uarx_pkg.sv */
`default_nettype none
package uarx_pkg;
  typedef enum logic [1:0]
  {
    UARX_IDLE  = 2'b00,
    UARX_START = 2'b01,
    UARX_DATA  = 2'b11,
    UARX_STOP  = 2'b10
  } uarx_state_type;
  typedef logic [7:0] uarx_byte_type;
endpackage
`default_nettype wire

/* File: logic/uarx_char_if.sv */
`default_nettype none
interface uarx_char_if;
  logic       tick;
  logic       done;
  logic [8:0] data;
  logic       stop_ok;
  modport core (input tick, output done, data, stop_ok);
  modport host (output tick, input done, data, stop_ok);
endinterface
`default_nettype wire

/* File: logic/uarx_tick.sv */
`include "uarx_cfg.svh"
`default_nettype none
module uarx_tick
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] divisor_in,
  output logic            tick_out
);
  import uarx_pkg::*;
  logic [7:0] count_reg;
  // =============================================================
  // one tick per divisor+1 clocks gives sixteen ticks per bit
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      count_reg <= 8'h00;
    else if (count_reg >= divisor_in)
      count_reg <= 8'h00;
    else
      count_reg <= count_reg + 8'h01;
  end
  assign tick_out = (count_reg >= divisor_in);
endmodule
`default_nettype wire

/* File: logic/uarx_rx_core.sv */
`include "uarx_cfg.svh"
`default_nettype none
module uarx_rx_core
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       enable_in,
  input  wire logic       nine_in,
  input  wire logic       line_in,
  uarx_char_if.core       chr
);
  import uarx_pkg::*;
  uarx_state_type state_reg;
  logic [3:0] phase_reg;
  logic [3:0] bitcnt_reg;
  logic [2:0] votes_reg;
  logic [8:0] shift_reg;
  logic       vote;
  logic       last;
  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
  assign vote = majority({votes_reg[1:0], line_in});
  assign last = chr.tick && phase_reg == `UARX_SAMPLE_C;
  // =============================================================
  // collect samples 8, 9 and 10
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      votes_reg <= 3'h0;
    else if (chr.tick && phase_reg >= `UARX_SAMPLE_A
             && phase_reg <= `UARX_SAMPLE_C)
      votes_reg <= {votes_reg[1:0], line_in};
  end
  // =============================================================
  // sampling phase within a bit
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || !enable_in)
      phase_reg <= 4'h0;
    else if (chr.tick)
    begin
      if (state_reg == UARX_IDLE)
        phase_reg <= 4'h1;
      else if (state_reg == UARX_STOP && phase_reg == `UARX_SAMPLE_C)
        phase_reg <= 4'h0;
      else
        phase_reg <= phase_reg + 4'h1;
    end
  end
  // =============================================================
  // frame sequencing
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || !enable_in)
      state_reg <= UARX_IDLE;
    else if (chr.tick)
    begin
      case (state_reg)
        UARX_IDLE:
          if (!line_in)
            state_reg <= UARX_START;
        UARX_START:
          if (phase_reg == `UARX_SAMPLE_C)
            state_reg <= vote ? UARX_IDLE : UARX_DATA;
        UARX_DATA:
          if (phase_reg == `UARX_SAMPLE_C && bitcnt_reg ==
              (nine_in ? `UARX_BITS_NINE : `UARX_BITS_EIGHT) - 4'h1)
            state_reg <= UARX_STOP;
        UARX_STOP:
          if (phase_reg == `UARX_SAMPLE_C)
            state_reg <= UARX_IDLE;
        default:
          state_reg <= UARX_IDLE;
      endcase
    end
  end
  // =============================================================
  // bit counter and data shifter
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      bitcnt_reg <= 4'h0;
      shift_reg  <= 9'h000;
    end
    else if (last && state_reg == UARX_START)
      bitcnt_reg <= 4'h0;
    else if (last && state_reg == UARX_DATA)
    begin
      bitcnt_reg <= bitcnt_reg + 4'h1;
      // lsb first: shift in from top, align at stop
      shift_reg  <= {vote, shift_reg[8:1]};
    end
    else if (phase_reg == 4'hF && chr.tick)
      bitcnt_reg <= bitcnt_reg;
  end
  // =============================================================
  // character hand-over, every frame regardless of stop bit
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      chr.done    <= 1'b0;
      chr.data    <= 9'h000;
      chr.stop_ok <= 1'b0;
    end
    else
    begin
      chr.done <= enable_in && last && state_reg == UARX_STOP;
      if (last && state_reg == UARX_STOP)
      begin
        chr.data    <= nine_in ? shift_reg : {1'b0, shift_reg[8:1]};
        chr.stop_ok <= vote;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/uarx_asserts.sv */
`include "uarx_cfg.svh"
`default_nettype none
module uarx_asserts
(
  input wire logic                    CLK_IN,
  input wire logic                    RESETN_IN,
  input wire logic [7:0]              ADDR_IN,
  input wire logic [7:0]              WDATA_IN,
  input wire logic                    WR_IN,
  input wire logic                    RD_IN,
  input wire uarx_pkg::uarx_byte_type RDATA_OUT,
  input wire logic                    GLOBAL_IRQ_EN_IN,
  input wire logic                    TX_LOADED_IN,
  input wire logic                    TX_IDLE_DONE_IN,
  input wire logic                    TXC_VECTOR_ACK_IN,
  input wire logic [7:0]              TX_DATA_OUT,
  input wire logic                    PIN_OE_OUT,
  input wire logic                    RX_IRQ_OUT,
  input wire logic                    TXC_IRQ_OUT,
  input wire logic                    EMPTY_IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  import uarx_pkg::*;
  // =========================
  // shadow of control writes
  logic [7:0] ctl_reg;
  logic       dw;
  logic       gie;
  assign dw = WR_IN && ADDR_IN == `UARX_ADDR_DATA;
  assign gie = GLOBAL_IRQ_EN_IN;
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
      ctl_reg <= 8'h00;
    else if (WR_IN && ADDR_IN == `UARX_ADDR_CONTROL)
      ctl_reg <= WDATA_IN;
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // =========================
  // properties
  rx_gate_a: assert property (
    RX_IRQ_OUT |-> gie && ctl_reg[7]) else $error("rx irq ungated");
  tx_gate_a: assert property (
    (TXC_IRQ_OUT |-> gie && ctl_reg[6]) and (EMPTY_IRQ_OUT |-> gie &&
    ctl_reg[5])) else $error("tx irq ungated");
  txd_load_a: assert property (
    dw |=> TX_DATA_OUT == $past(WDATA_IN)) else $error("tx buffer");
  st_rsvd_a: assert property (
    RD_IN && ADDR_IN == `UARX_ADDR_STATUS |=> RDATA_OUT[2:0] == 3'h0)
    else $error("reserved bits set");
  rx_clear_a: assert property (
    RD_IN && ADDR_IN == `UARX_ADDR_DATA |=> !RX_IRQ_OUT)
    else $error("rx done not cleared");
  empty_set_a: assert property (
    TX_LOADED_IN && !dw ##1 gie && ctl_reg[5] |-> EMPTY_IRQ_OUT)
    else $error("empty not set");
  empty_clr_a: assert property (
    dw && !TX_LOADED_IN |=> !EMPTY_IRQ_OUT) else $error("empty not clear");
  txc_set_a: assert property (
    TX_IDLE_DONE_IN && ctl_reg[4] ##1 gie && ctl_reg[6] |-> TXC_IRQ_OUT)
    else $error("tx done not set");
  txc_ack_a: assert property (
    TXC_VECTOR_ACK_IN && !TX_IDLE_DONE_IN |=> !TXC_IRQ_OUT)
    else $error("tx done not acked");
  txc_off_a: assert property (
    !TXC_IRQ_OUT && gie && ctl_reg[6] && !ctl_reg[4] ##1 gie && ctl_reg[6]
    |-> !TXC_IRQ_OUT) else $error("tx done set with receiver off");
  pin_in_a: assert property (
    ctl_reg[4] |-> !PIN_OE_OUT) else $error("pin driven in rx mode");
  cover property (RX_IRQ_OUT);
  cover property (TXC_IRQ_OUT);
  cover property (dw);
endmodule
`default_nettype wire

/* File: tb/uarx_line_model.sv */
`default_nettype none
module uarx_line_model
(
  input  wire logic       clk_in,
  input  wire logic       send_in,
  input  wire logic [8:0] data_in,
  input  wire logic       nine_in,
  input  wire logic       stop_in,
  input  wire logic       short_in,
  input  wire logic [7:0] clks_in,
  output logic            line_out,
  output logic            busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] frame_reg = 11'h7FF;
  logic [3:0]  bit_reg = 4'h0;
  logic [3:0]  last_reg = 4'h9;
  logic [7:0]  cnt_reg = 8'h00;
  logic        short_reg = 1'b0;
  initial
    busy_out = 1'b0;
  // short mode: start low for four clocks only, then high
  assign line_out = !busy_out | frame_reg[bit_reg] |
                    (short_reg && (bit_reg != 4'h0 || cnt_reg > 8'h03));
  always @(posedge clk_in)
  begin
    if (!busy_out && send_in)
    begin
      frame_reg <= nine_in ? {stop_in, data_in, 1'b0}
                           : {1'b1, stop_in, data_in[7:0], 1'b0};
      last_reg <= nine_in ? 4'hA : 4'h9;
      bit_reg <= 4'h0;
      cnt_reg <= 8'h00;
      short_reg <= short_in;
      busy_out <= 1'b1;
    end
    else if (busy_out && cnt_reg == clks_in - 8'h01)
    begin
      cnt_reg <= 8'h00;
      bit_reg <= bit_reg + 4'h1;
      busy_out <= bit_reg != last_reg;
    end
    else if (busy_out)
      cnt_reg <= cnt_reg + 8'h01;
  end
endmodule
`default_nettype wire

/* File: tb/uarx_top_tb.sv */
`include "uarx_cfg.svh"
`default_nettype none
module uarx_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import uarx_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, gie = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, txd, clks = 8'h10;
  logic [2:0] ev = 3'h0;
  logic [8:0] sd = 9'h000;
  logic send = 1'b0, nine = 1'b0, stp = 1'b1, shrt = 1'b0, gpio = 1'b1;
  logic line, busy, tx9, pin, oe, pu, irq_rx, irq_txc, irq_em;
  uarx_byte_type rdata;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  uarx_top uarx_top_i (.CLK_IN(clk), .RESETN_IN(resetn), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .GLOBAL_IRQ_EN_IN(gie), .TX_LOADED_IN(ev[0]), .TX_IDLE_DONE_IN(ev[1]),
    .TXC_VECTOR_ACK_IN(ev[2]), .TX_DATA_OUT(txd), .TX_NINTH_OUT(tx9),
    .SHARED_INPUT_PIN_IN(line), .PIN_GPIO_OUT_IN(gpio), .PIN_OUT(pin),
    .PIN_OE_OUT(oe), .PIN_PULLUP_OUT(pu), .RX_IRQ_OUT(irq_rx),
    .TXC_IRQ_OUT(irq_txc), .EMPTY_IRQ_OUT(irq_em));
  uarx_line_model uarx_line_model_i (.clk_in(clk), .send_in(send),
    .data_in(sd), .nine_in(nine), .stop_in(stp), .short_in(shrt),
    .clks_in(clks), .line_out(line), .busy_out(busy));
  initial
    forever #50 clk = !clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      test_done();
    end
  end
  // =========================
  // helpers
  task automatic chk(input string w, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wrt(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [7:0] a, e, input string w);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(w, e, rdata);
  endtask
  task automatic pls(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    #1;
  endtask
  task automatic snd(input logic [8:0] d, input logic s, sh);
    // wait on edges so a frame launched by the previous call is seen busy
    @(posedge clk);
    while (busy)
      @(posedge clk);
    sd <= d;
    stp <= s;
    shrt <= sh;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
  endtask
  task automatic idle;
    @(posedge clk);
    while (busy)
      @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // =========================
  // scenarios
  task automatic t_reset;
    rc(`UARX_ADDR_STATUS, 8'h20, "status");
    rc(`UARX_ADDR_CONTROL, 8'h00, "control");
    rc(8'h3F, 8'h00, "unmapped");
    $display("reset test done");
  endtask
  task automatic t_rx;
    wrt(`UARX_ADDR_PORT, 8'h03);
    chk("oe", 8'h01, {7'h0, oe});
    chk("pin", 8'h01, {7'h0, pin});
    wrt(`UARX_ADDR_CONTROL, 8'h90);
    chk("oe", 8'h00, {7'h0, oe});
    chk("pullup", 8'h01, {7'h0, pu});
    wrt(`UARX_ADDR_DATA, 8'h3C);
    snd(9'h0A5, 1'b1, 1'b0);
    idle();
    chk("rx irq", 8'h01, {7'h0, irq_rx});
    wrt(`UARX_ADDR_CONTROL, 8'h10);
    chk("rx irq", 8'h00, {7'h0, irq_rx});
    wrt(`UARX_ADDR_CONTROL, 8'h90);
    rc(`UARX_ADDR_STATUS, 8'h80, "status");
    rc(`UARX_ADDR_DATA, 8'hA5, "rx data");
    chk("rx irq", 8'h00, {7'h0, irq_rx});
    chk("tx data", 8'h3C, txd);
    wrt(`UARX_ADDR_DIVISOR, 8'h01);
    clks = 8'h20;
    snd(9'h0C3, 1'b1, 1'b0);
    idle();
    rc(`UARX_ADDR_DATA, 8'hC3, "rx data");
    wrt(`UARX_ADDR_DIVISOR, 8'h00);
    clks = 8'h10;
    $display("receive test done");
  endtask
  task automatic t_frame;
    snd(9'h03C, 1'b0, 1'b0);
    idle();
    rc(`UARX_ADDR_STATUS, 8'h90, "status");
    rc(`UARX_ADDR_DATA, 8'h3C, "rx data");
    snd(9'h066, 1'b1, 1'b0);
    idle();
    rc(`UARX_ADDR_STATUS, 8'h80, "status");
    rc(`UARX_ADDR_DATA, 8'h66, "rx data");
    snd(9'h000, 1'b1, 1'b1);
    idle();
    rc(`UARX_ADDR_STATUS, 8'h00, "status");
    snd(9'h081, 1'b1, 1'b0);
    idle();
    rc(`UARX_ADDR_DATA, 8'h81, "rx data");
    $display("framing test done");
  endtask
  task automatic t_over;
    snd(9'h011, 1'b1, 1'b0);
    snd(9'h022, 1'b1, 1'b0);
    idle();
    rc(`UARX_ADDR_STATUS, 8'h80, "status");
    rc(`UARX_ADDR_DATA, 8'h11, "rx data");
    rc(`UARX_ADDR_STATUS, 8'h08, "status");
    snd(9'h033, 1'b1, 1'b0);
    idle();
    rc(`UARX_ADDR_STATUS, 8'h80, "status");
    rc(`UARX_ADDR_DATA, 8'h33, "rx data");
    nine = 1'b1;
    wrt(`UARX_ADDR_CONTROL, 8'h95);
    chk("tx ninth", 8'h01, {7'h0, tx9});
    snd(9'h15A, 1'b1, 1'b0);
    idle();
    rc(`UARX_ADDR_CONTROL, 8'h96, "control");
    rc(`UARX_ADDR_DATA, 8'h5A, "rx data");
    snd(9'h0A5, 1'b1, 1'b0);
    idle();
    rc(`UARX_ADDR_CONTROL, 8'h94, "control");
    rc(`UARX_ADDR_DATA, 8'hA5, "rx data");
    nine = 1'b0;
    $display("overrun test done");
  endtask
  task automatic t_tx;
    wrt(`UARX_ADDR_CONTROL, 8'hF0);
    pls(0);
    chk("empty irq", 8'h01, {7'h0, irq_em});
    @(posedge clk);
    gie <= 1'b0;
    gpio <= 1'b0;
    #1;
    chk("empty irq", 8'h00, {7'h0, irq_em});
    chk("pin", 8'h00, {7'h0, pin});
    gie <= 1'b1;
    wrt(`UARX_ADDR_DATA, 8'h5A);
    chk("empty irq", 8'h00, {7'h0, irq_em});
    chk("tx data", 8'h5A, txd);
    pls(1);
    chk("txc irq", 8'h01, {7'h0, irq_txc});
    wrt(`UARX_ADDR_STATUS, 8'h40);
    chk("txc irq", 8'h00, {7'h0, irq_txc});
    pls(1);
    pls(2);
    chk("txc irq", 8'h00, {7'h0, irq_txc});
    pls(1);
    wrt(`UARX_ADDR_CONTROL, 8'h60);
    rc(`UARX_ADDR_STATUS, 8'h40, "status");
    wrt(`UARX_ADDR_STATUS, 8'h40);
    pls(1);
    rc(`UARX_ADDR_STATUS, 8'h00, "status");
    $display("transmit flag test done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_rx();
    t_frame();
    t_over();
    t_tx();
    test_done();
  end
endmodule
bind uarx_top uarx_asserts uarx_asserts_i (.CLK_IN(CLK_IN),
  .RESETN_IN(RESETN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .GLOBAL_IRQ_EN_IN(GLOBAL_IRQ_EN_IN), .TX_LOADED_IN(TX_LOADED_IN),
  .TX_IDLE_DONE_IN(TX_IDLE_DONE_IN), .TXC_VECTOR_ACK_IN(TXC_VECTOR_ACK_IN),
  .TX_DATA_OUT(TX_DATA_OUT), .PIN_OE_OUT(PIN_OE_OUT),
  .RX_IRQ_OUT(RX_IRQ_OUT), .TXC_IRQ_OUT(TXC_IRQ_OUT),
  .EMPTY_IRQ_OUT(EMPTY_IRQ_OUT));
`default_nettype wire
